// ---- design/ssp_ctrl.sv ----
// Synchronous serial port: AXI4-Lite registers, transmit and receive control
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"
module ssp_ctrl (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Baud rate generator output, one-cycle pulses
  input  wire logic        baud_tick,
  // Transmit pins
  input  wire logic        tx_clock_i,
  output logic             tx_clock_o,
  output logic             tx_clock_oe_n,
  output logic             tx_data_o,
  // Receive pins
  input  wire logic        rx_clock_i,
  output logic             rx_clock_o,
  output logic             rx_clock_oe_n,
  input  wire logic        rx_data_i,
  // Interrupt requests
  output logic             tx_irq,
  output logic             rx_irq
);

  // Write channel holding
  logic        aw_held_r;
  logic [11:0] aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_fire;
  logic        wr_lane;
  logic        wr_mapped;

  // Register state
  logic        rx_en_r;
  logic        trx_mst_r;
  logic        tx_mst_r;
  logic        oerr_r;
  logic        rx_ie_r;
  logic        rx_req_r;
  logic        tx_ie_r;
  logic        tx_req_r;
  logic [7:0]  tx_buf_r;
  logic [7:0]  rx_buf_r;
  logic        rx_unread_r;
  ssp_pkg::tx_state_t tx_state_r;
  ssp_pkg::tx_state_t tx_state_nxt;

  // Shift engines
  logic        tx_load;
  logic        rx_load;
  logic [7:0]  rx_shift;
  logic        rx_done;
  logic        rd_fire;
  logic        rd_dbuf;
  logic [7:0]  rd_val;
  logic        rd_ok;

  ssp_link_if tx_link ();
  ssp_link_if rx_link ();

  // Reset images, so single fields can be picked out
  localparam logic [7:0] trx_ctl_rst = `TRX_CTL_RST;
  localparam logic [7:0] tx_ctl_rst  = `TX_CTL_RST;
  localparam logic [7:0] stat_rst    = `STAT_RST;

  // ---------------------------------------------------------------
  // AXI4-Lite write side: address and data taken in either order
  // ---------------------------------------------------------------
  assign awready = !aw_held_r && !bvalid;
  assign wready  = !w_held_r && !bvalid;
  assign wr_fire = aw_held_r && w_held_r && !bvalid;
  assign wr_lane = wr_fire && w_strb_r[0];

  always_comb
  begin
    unique case (aw_addr_r)
      `DBUF_ADDR, `STAT_ADDR, `TX_CTL_ADDR, `TRX_CTL_ADDR: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
    end
    else if (awvalid && awready)
    begin
      aw_held_r <= 1'b1;
      aw_addr_r <= awaddr;
    end
    else if (wr_fire)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_held_r <= 1'b1;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end
    else if (wr_fire)
      w_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read side
  // ---------------------------------------------------------------
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;
  assign rd_dbuf = rd_fire && (araddr == `DBUF_ADDR);

  always_comb
  begin
    rd_ok = 1'b1;
    unique case (araddr)
      `DBUF_ADDR:    rd_val = rx_buf_r;
      `STAT_ADDR:    rd_val = {tx_req_r, tx_ie_r, rx_req_r, rx_ie_r, 2'h0, oerr_r, 1'b0};
      `TX_CTL_ADDR:  rd_val = {1'b1, 2'h0, tx_mst_r, `CTL_FIXED_LOW};
      `TRX_CTL_ADDR: rd_val = {rx_en_r, 2'h0, trx_mst_r, `CTL_FIXED_LOW};
      default:
      begin
        rd_val = 8'h00;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // shift registers never on the read mux
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_val};
      rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // reset to 0EH, enable and mode bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_en_r   <= trx_ctl_rst[`CTL_EN_BIT];
      trx_mst_r <= trx_ctl_rst[`CTL_MST_BIT];
    end
    else if (wr_lane && aw_addr_r == `TRX_CTL_ADDR)
    begin
      rx_en_r   <= w_data_r[`CTL_EN_BIT];
      trx_mst_r <= w_data_r[`CTL_MST_BIT];
    end
    else if (rx_done && trx_mst_r)
      rx_en_r <= 1'b0;
  end

  // reset to 8EH, transmit mode bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_mst_r <= tx_ctl_rst[`CTL_MST_BIT];
    else if (wr_lane && aw_addr_r == `TX_CTL_ADDR)
      tx_mst_r <= w_data_r[`CTL_MST_BIT];
  end

  // ---------------------------------------------------------------
  // Status register; hardware set wins over software clear
  // ---------------------------------------------------------------
  // status resets to 00H
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_ie_r <= stat_rst[`STAT_RXIE_BIT];
      tx_ie_r <= stat_rst[`STAT_TXIE_BIT];
    end
    else if (wr_lane && aw_addr_r == `STAT_ADDR)
    begin
      rx_ie_r <= w_data_r[`STAT_RXIE_BIT];
      tx_ie_r <= w_data_r[`STAT_TXIE_BIT];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      oerr_r <= stat_rst[`STAT_OERR_BIT];
    else if (rx_done && rx_unread_r)
      oerr_r <= 1'b1;
    else if (wr_lane && aw_addr_r == `STAT_ADDR)
      oerr_r <= w_data_r[`STAT_OERR_BIT];
  end

  // receive request, cleared only by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_req_r <= stat_rst[`STAT_RXRQ_BIT];
    else if (rx_done)
      rx_req_r <= 1'b1;
    else if (wr_lane && aw_addr_r == `STAT_ADDR)
      rx_req_r <= w_data_r[`STAT_RXRQ_BIT];
  end

  // transmit request, cleared only by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_req_r <= stat_rst[`STAT_TXRQ_BIT];
    else if (tx_load)
      tx_req_r <= 1'b1;
    else if (wr_lane && aw_addr_r == `STAT_ADDR)
      tx_req_r <= w_data_r[`STAT_TXRQ_BIT];
  end

  assign tx_irq = tx_req_r && tx_ie_r;
  assign rx_irq = rx_req_r && rx_ie_r;

  // ---------------------------------------------------------------
  // Transmit side
  // ---------------------------------------------------------------
  // write loads transmit buffer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_buf_r <= 8'h00;
    else if (wr_lane && aw_addr_r == `DBUF_ADDR)
      tx_buf_r <= w_data_r[7:0];
  end

  // start one clock after the write
  always_comb
  begin
    tx_state_nxt = tx_state_r;
    unique case (tx_state_r)
      ssp_pkg::TX_IDLE:
        if (wr_lane && aw_addr_r == `DBUF_ADDR)
          tx_state_nxt = ssp_pkg::TX_PEND;
      ssp_pkg::TX_PEND:
        tx_state_nxt = tx_link.run ? ssp_pkg::TX_WAIT : ssp_pkg::TX_IDLE;
      ssp_pkg::TX_WAIT:
        if (!tx_link.run)
          tx_state_nxt = ssp_pkg::TX_IDLE;
      default:
        tx_state_nxt = ssp_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_state_r <= ssp_pkg::TX_IDLE;
    else
      tx_state_r <= tx_state_nxt;
  end

  // A frame in flight is never cut; a new byte waits for it
  assign tx_load = (tx_state_r != ssp_pkg::TX_IDLE) && !tx_link.run;

  // transmit clock per its own mode bit
  ssp_clk_gen u_tx_clk (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .master    (tx_mst_r),
    .baud_tick (baud_tick),
    .pin_i     (tx_clock_i),
    .pin_o     (tx_clock_o),
    .pin_oe_n  (tx_clock_oe_n),
    .link      (tx_link.gen)
  );

  ssp_shifter u_tx_shift (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load      (tx_load),
    .load_data (tx_buf_r),
    .sin       (1'b0),
    .sout      (tx_data_o),
    .data      (),
    .done      (),
    .link      (tx_link.shf)
  );

  // ---------------------------------------------------------------
  // Receive side
  // ---------------------------------------------------------------
  // enable starts a frame; slave rearms itself
  assign rx_load = rx_en_r && !rx_link.run && !rx_done;

  ssp_clk_gen u_rx_clk (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .master    (trx_mst_r),
    .baud_tick (baud_tick),
    .pin_i     (rx_clock_i),
    .pin_o     (rx_clock_o),
    .pin_oe_n  (rx_clock_oe_n),
    .link      (rx_link.gen)
  );

  ssp_shifter u_rx_shift (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load      (rx_load),
    .load_data (8'h00),
    .sin       (rx_data_i),
    .sout      (),
    .data      (rx_shift),
    .done      (rx_done),
    .link      (rx_link.shf)
  );

  // copy at frame end, hold otherwise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_buf_r <= 8'h00;
    else if (rx_done)
      rx_buf_r <= rx_shift;
  end

  // Unread byte tracking for overrun; new frame wins over a read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_unread_r <= 1'b0;
    else if (rx_done)
      rx_unread_r <= 1'b1;
    else if (rd_dbuf)
      rx_unread_r <= 1'b0;
  end

endmodule
`default_nettype wire

// ---- design/ssp_map.svh ----
// Register map, field positions, reset values and timing counts of the serial port
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// Register indices; the byte address is four times the index
`define DBUF_IDX        10'h0F6
`define STAT_IDX        10'h0F7
`define TX_CTL_IDX      10'h11B
`define TRX_CTL_IDX     10'h11C
`define DBUF_ADDR       {`DBUF_IDX, 2'h0}
`define STAT_ADDR       {`STAT_IDX, 2'h0}
`define TX_CTL_ADDR     {`TX_CTL_IDX, 2'h0}
`define TRX_CTL_ADDR    {`TRX_CTL_IDX, 2'h0}

// Control register fields
`define CTL_MST_BIT     4
`define CTL_EN_BIT      7
`define CTL_FIXED_LOW   4'hE
`define TRX_CTL_RST     8'h0E
`define TX_CTL_RST      8'h8E

// Status register fields
`define STAT_OERR_BIT   1
`define STAT_RXIE_BIT   4
`define STAT_RXRQ_BIT   5
`define STAT_TXIE_BIT   6
`define STAT_TXRQ_BIT   7
`define STAT_RST        8'h00

// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Shift clock: baud ticks divided by four, low in phase 0..1, high in 2..3
`define PHASE_FALL      2'h3
`define PHASE_RISE      2'h1
`define LAST_BIT        3'h7

`endif

// ---- design/ssp_pkg.sv ----
// Types shared by the serial port modules
package ssp_pkg;

  // Transmit start sequencing; one bit changes per step except TX_WAIT back to TX_IDLE
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_PEND = 2'h1,
    TX_WAIT = 2'h3
  } tx_state_t;

endpackage

// ---- design/ssp_link_if.sv ----
// Shift-clock strobes between a clock generator and its shifter
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
  logic run;
  logic rise;
  logic fall;

  modport gen (input run, output rise, output fall);
  modport shf (output run, input rise, input fall);
endinterface
`default_nettype wire

// ---- design/ssp_clk_gen.sv ----
// Shift clock generator: divide-by-four master clock or slave edge detector
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"
module ssp_clk_gen (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Mode and baud source
  input  wire logic master,
  input  wire logic baud_tick,
  // Clock pin
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe_n,
  // Strobes to shifter
  ssp_link_if.gen   link
);
  logic [1:0] phase_r;
  logic       clk_r;
  logic       prev_r;
  logic       m_fall;
  logic       m_rise;

  assign m_fall = link.run && baud_tick && (phase_r == `PHASE_FALL);
  // No rise before the first fall, else a frame ends after only seven falls
  assign m_rise = link.run && baud_tick && (phase_r == `PHASE_RISE) && !clk_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !link.run || !master)
      phase_r <= 2'h0;
    else if (baud_tick)
      phase_r <= phase_r + 2'h1;
  end

  // Idle high, so the first edge of a frame is a fall
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !link.run || !master)
      clk_r <= 1'b1;
    else if (m_fall)
      clk_r <= 1'b0;
    else if (m_rise)
      clk_r <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_r <= 1'b1;
    else
      prev_r <= pin_i;
  end

  assign link.fall = master ? m_fall : (link.run && prev_r && !pin_i);
  assign link.rise = master ? m_rise : (link.run && !prev_r && pin_i);
  assign pin_o     = clk_r;
  assign pin_oe_n  = !master;
endmodule
`default_nettype wire

// ---- design/ssp_shifter.sv ----
// Eight-bit LSB-first shift register with bit counter
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"
module ssp_shifter (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Frame start and data
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  input  wire logic       sin,
  output logic            sout,
  output logic [7:0]      data,
  output logic            done,
  // Strobes from clock generator
  ssp_link_if.shf         link
);
  logic [2:0] cnt_r;
  logic       busy_r;

  assign link.run = busy_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data   <= 8'h00;
      cnt_r  <= 3'h0;
      busy_r <= 1'b0;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load)
      begin
        data   <= load_data;
        cnt_r  <= 3'h0;
        busy_r <= 1'b1;
      end
      else if (busy_r && link.rise)
      begin
        data  <= {sin, data[7:1]};
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == `LAST_BIT)
        begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sout <= 1'b1;
    else if (busy_r && link.fall)
      sout <= data[0];
  end
endmodule
`default_nettype wire

// ---- verification/ssp_ctrl_assertions.sv ----
// Concurrent checks on the serial port's bus handshakes and shift pins
`timescale 1ns/1ps
`default_nettype none
module ssp_ctrl_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Serial side
  input wire logic        baud_tick,
  input wire logic        tx_clock_o,
  input wire logic        tx_clock_oe_n,
  input wire logic        tx_data_o,
  input wire logic        rx_clock_o,
  input wire logic        rx_clock_oe_n,
  input wire logic        tx_irq,
  input wire logic        rx_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  chk_rd_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  chk_rd_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  chk_rst_state: assert property ($rose(aresetn) |-> tx_clock_oe_n
    && rx_clock_oe_n && tx_data_o && !tx_irq && !rx_irq)
    else $error("state after reset wrong");
  chk_tx_fall: assert property ($fell(tx_clock_o) |-> !tx_clock_oe_n
    && $past(baud_tick))
    else $error("transmit clock fell without baud tick");
  chk_rx_rise: assert property ($rose(rx_clock_o) |-> !rx_clock_oe_n
    && $past(baud_tick))
    else $error("receive clock rose without baud tick");
  chk_data_fall: assert property (!tx_clock_oe_n && $changed(tx_data_o)
    |-> $fell(tx_clock_o))
    else $error("data changed off a clock fall");
endmodule

bind ssp_ctrl ssp_ctrl_assertions u_ssp_ctrl_assertions (
  .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .baud_tick(baud_tick), .tx_clock_o(tx_clock_o), .tx_clock_oe_n(tx_clock_oe_n),
  .tx_data_o(tx_data_o), .rx_clock_o(rx_clock_o), .rx_clock_oe_n(rx_clock_oe_n),
  .tx_irq(tx_irq), .rx_irq(rx_irq)
);
`default_nettype wire

// ---- verification/ssp_partner.sv ----
// Far-end serial device: slave clock source, data sender and byte listener
`timescale 1ns/1ps
`default_nettype none
module ssp_partner (
  // Clock
  input  wire logic       aclk,
  // Bench control
  input  wire logic       go,
  input  wire logic [7:0] send,
  output logic            ext_clk,
  output logic [7:0]      heard,
  output logic [7:0]      heard_frames,
  // Serial wires
  input  wire logic       rx_wire,
  input  wire logic       tx_wire,
  input  wire logic       tx_data,
  output logic            rx_data
);
  logic [6:0] gen_cnt = 7'h00;
  logic [6:0] ph;
  logic [7:0] sh = 8'h00;
  logic [2:0] out_idx = 3'h0;
  logic [2:0] in_idx = 3'h0;
  logic [3:0] quiet = 4'hF;
  logic       rx_prev = 1'b1;
  logic       tx_prev = 1'b1;

  initial heard = 8'h00;
  initial heard_frames = 8'h00;
  initial rx_data = 1'b0;

  // Clock stands high between frames; each bit is four low, four high
  assign ph = gen_cnt - 7'h01;
  assign ext_clk = (gen_cnt == 7'h00) | ~ph[2];

  always_ff @(posedge aclk)
  begin
    if (go)
      gen_cnt <= 7'h40;
    else if (gen_cnt != 7'h00)
      gen_cnt <= gen_cnt - 7'h01;
  end

  always @(posedge aclk)
  begin
    rx_prev <= rx_wire;
    quiet <= (!rx_prev && rx_wire) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    if (rx_prev && !rx_wire)
    begin
      rx_data <= send[out_idx];
      out_idx <= out_idx + 3'h1;
    end
    else if (out_idx == 3'h0 && quiet == 4'hF)
      rx_data <= ~rx_data;
  end

  always @(posedge aclk)
  begin
    tx_prev <= tx_wire;
    if (!tx_prev && tx_wire)
    begin
      sh <= {tx_data, sh[7:1]};
      in_idx <= in_idx + 3'h1;
      if (in_idx == 3'h7)
      begin
        heard <= {tx_data, sh[7:1]};
        heard_frames <= heard_frames + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_ssp_ctrl.sv ----
// Self-checking bench for the serial port: bus tasks, partner traffic, verdict
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"
module test_ssp_ctrl;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, go;
  logic        baud_tick = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, tx_irq, rx_irq, tx_data_o;
  logic        tx_clock_o, tx_clock_oe_n, rx_clock_o, rx_clock_oe_n;
  logic        ext_clk, rx_data, tx_wire, rx_wire;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [7:0]  send, heard, heard_frames, seen;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [7:0]  stat_tab [5] = '{8'h50, 8'hA2, 8'hC0, 8'h32, 8'h00};
  int          miscompares = 0;
  int          comparisons = 0;

  // Released clock pins follow the partner
  assign tx_wire = tx_clock_oe_n ? ext_clk : tx_clock_o;
  assign rx_wire = rx_clock_oe_n ? ext_clk : rx_clock_o;

  always #25 aclk = ~aclk;
  // One-cycle baud pulse every other cycle
  always @(posedge aclk) baud_tick <= !baud_tick;

  ssp_ctrl u_ssp_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .baud_tick(baud_tick), .tx_data_o(tx_data_o), .rx_data_i(rx_data),
    .tx_clock_i(tx_wire), .tx_clock_o(tx_clock_o), .tx_clock_oe_n(tx_clock_oe_n),
    .rx_clock_i(rx_wire), .rx_clock_o(rx_clock_o), .rx_clock_oe_n(rx_clock_oe_n),
    .tx_irq(tx_irq), .rx_irq(rx_irq)
  );

  ssp_partner u_ssp_partner (
    .aclk(aclk), .go(go), .send(send), .ext_clk(ext_clk), .heard(heard),
    .heard_frames(heard_frames), .rx_wire(rx_wire), .tx_wire(tx_wire),
    .tx_data(tx_data_o), .rx_data(rx_data)
  );

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic write_reg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    compare({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic read_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic expect_reg(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    read_reg(a, d, r);
    compare(d, e);
    compare({30'h0, r}, {30'h0, er});
  endtask

  // Polls until the receive request shows a finished frame
  task automatic wait_rx;
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h0;
    while (d[5] !== 1'b1)
      read_reg(`STAT_ADDR, d, r);
  endtask

  task automatic slave_frame(input logic [7:0] b);
    send <= b;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    wait_rx;
  endtask

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (6000) @(posedge aclk);
    miscompares++;
    close_out;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 7'h00;
    {awaddr, araddr, wdata, wstrb, send} = 68'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    expect_reg(`TRX_CTL_ADDR, 32'h0E, `RESP_OKAY);
    expect_reg(`TX_CTL_ADDR, 32'h8E, `RESP_OKAY);
    expect_reg(`STAT_ADDR, 32'h00, `RESP_OKAY);
    compare({30'h0, tx_clock_oe_n, rx_clock_oe_n}, 32'h3);
    write_reg(`TRX_CTL_ADDR, 32'h10, `RESP_OKAY);
    write_reg(`TX_CTL_ADDR, 32'h10, `RESP_OKAY);
    expect_reg(`TRX_CTL_ADDR, 32'h1E, `RESP_OKAY);
    expect_reg(`TX_CTL_ADDR, 32'h9E, `RESP_OKAY);
    compare({30'h0, tx_clock_oe_n, rx_clock_oe_n}, 32'h0);
    write_reg(`TRX_CTL_ADDR, 32'h00, `RESP_OKAY);
    write_reg(`TX_CTL_ADDR, 32'h00, `RESP_OKAY);
    for (int i = 0; i < 5; i++)
    begin
      write_reg(`STAT_ADDR, {24'h0, stat_tab[i]}, `RESP_OKAY);
      expect_reg(`STAT_ADDR, {24'h0, stat_tab[i]}, `RESP_OKAY);
      compare({30'h0, tx_irq, rx_irq}, {30'h0, &stat_tab[i][7:6], &stat_tab[i][5:4]});
    end
    write_reg(12'h3E0, 32'h55, `RESP_SLVERR);
    expect_reg(12'h3E0, 32'h00, `RESP_SLVERR);
    write_reg(`DBUF_ADDR, 32'hA5, `RESP_OKAY);
    write_reg(`TRX_CTL_ADDR, 32'h80, `RESP_OKAY);
    slave_frame(8'h3C);
    compare({24'h0, heard}, 32'hA5);
    expect_reg(`STAT_ADDR, 32'hA0, `RESP_OKAY);
    expect_reg(`DBUF_ADDR, 32'h3C, `RESP_OKAY);
    expect_reg(`DBUF_ADDR, 32'h3C, `RESP_OKAY);
    expect_reg(`TRX_CTL_ADDR, 32'h8E, `RESP_OKAY);
    write_reg(`STAT_ADDR, 32'h00, `RESP_OKAY);
    slave_frame(8'hC3);
    write_reg(`STAT_ADDR, 32'h00, `RESP_OKAY);
    slave_frame(8'h5A);
    expect_reg(`STAT_ADDR, 32'h22, `RESP_OKAY);
    expect_reg(`DBUF_ADDR, 32'h5A, `RESP_OKAY);
    write_reg(`STAT_ADDR, 32'h02, `RESP_OKAY);
    slave_frame(8'h0F);
    expect_reg(`STAT_ADDR, 32'h22, `RESP_OKAY);
    expect_reg(`DBUF_ADDR, 32'h0F, `RESP_OKAY);
    write_reg(`STAT_ADDR, 32'h00, `RESP_OKAY);
    write_reg(`TRX_CTL_ADDR, 32'h00, `RESP_OKAY);
    write_reg(`TX_CTL_ADDR, 32'h10, `RESP_OKAY);
    send <= 8'h69;
    seen = heard_frames;
    // Mode set while the receiver is still armed from the slave frames, then the byte is written
    write_reg(`TRX_CTL_ADDR, 32'h90, `RESP_OKAY);
    write_reg(`DBUF_ADDR, 32'h96, `RESP_OKAY);
    wait_rx;
    while (heard_frames === seen)
      @(posedge aclk);
    compare({24'h0, heard}, 32'h96);
    expect_reg(`TRX_CTL_ADDR, 32'h1E, `RESP_OKAY);
    expect_reg(`DBUF_ADDR, 32'h69, `RESP_OKAY);
    expect_reg(`STAT_ADDR, 32'hA0, `RESP_OKAY);
    close_out;
  end
endmodule
`default_nettype wire
